// ===== src/itrm_pkg.sv
package itrm_pkg;

    // ----------------------------------------------------------------
    // Register addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_PAYLOAD = 8'h80;
    localparam logic [7:0] REG_WIN_LEN = 8'h81;
    localparam logic [7:0] REG_LINK_STATE = 8'h82;
    localparam logic [7:0] REG_TARGET_ADDR = 8'h83;
    localparam logic [7:0] REG_TOP_RATE = 8'h84;
    localparam logic [7:0] REG_GAP = 8'h85;
    localparam logic [7:0] REG_SPEED_MODE = 8'h89;

    // ----------------------------------------------------------------
    // Values after reset, limits and field positions
    // ----------------------------------------------------------------
    localparam logic [6:0] DEF_TARGET_ADDR = 7'h30;
    localparam logic [15:0] MIN_WIN_LEN = 16'h0010;
    localparam logic [15:0] MAX_WIN_LEN = 16'h0200;
    localparam logic [15:0] FRAME_OVERHEAD = 16'h0005;
    localparam int ADDR_PERSIST_BIT = 15;
    localparam logic [5:0] FEATURE_BITS = 6'h02;
    localparam logic [7:0] LAYER_BITS = 8'h00;
    localparam logic [31:0] GAP_VALUE = 32'h0000_00c8;
    localparam logic [31:0] UNMAPPED_WORD = 32'hffff_ffff;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [2:0] REG16_BYTES = 3'h2;

    // ----------------------------------------------------------------
    // Bus speed codes and the rates they allow
    // ----------------------------------------------------------------
    localparam logic [2:0] MODE_SM = 3'h1;
    localparam logic [2:0] MODE_FM = 3'h2;
    localparam logic [2:0] MODE_SM_FM = 3'h3;
    localparam logic [2:0] MODE_FMP = 3'h4;
    localparam logic [31:0] RATE_SM_KHZ = 32'd100;
    localparam logic [31:0] RATE_FM_KHZ = 32'd400;
    localparam logic [31:0] RATE_FMP_KHZ = 32'd1000;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ADDR_ACK = 3'b011,
        ST_RX_BYTE = 3'b010,
        ST_RX_ACK = 3'b110,
        ST_TX_BYTE = 3'b111,
        ST_TX_ACK = 3'b101
    } itrm_fsm_t;

    typedef struct packed {
        logic busy;
        logic response_waiting;
        logic [15:0] resp_len;
    } itrm_status_t;

    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic scl_f;
        logic sda_f;
        itrm_fsm_t fsm;
        logic [3:0] bcnt;
        logic [7:0] sh;
        logic rw;
        logic ptr_ok;
        logic [7:0] ptr;
        logic nack;
        logic [31:0] rdsh;
        logic [31:0] wsh;
        logic [2:0] wcnt;
        logic [15:0] len_act;
        logic [15:0] len_pend;
        logic [6:0] addr_act;
        logic [6:0] addr_pend;
        logic [2:0] mode;
        logic loaded;
        logic sda_oe;
        logic [7:0] rx_byte;
        logic rx_valid;
        logic tx_taken;
        logic persist_wr;
        logic [6:0] persist_addr;
        logic [15:0] payload;
    } itrm_state_t;

endpackage : itrm_pkg

// ===== src/itrm_target.sv
`timescale 1ns/100ps
`default_nettype none

module itrm_target (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire itrm_pkg::itrm_status_t status,
    input wire logic [7:0] tx_data,
    output logic tx_taken,
    output logic [7:0] rx_byte,
    output logic rx_valid,
    input wire logic stored_valid,
    input wire logic [6:0] stored_addr,
    output logic persist_wr,
    output logic [6:0] persist_addr,
    output logic [15:0] max_frame_payload
);

    itrm_pkg::itrm_state_t s;
    itrm_pkg::itrm_state_t n;
    logic scl_new;
    logic sda_new;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic [31:0] rate_khz;
    logic [31:0] rd_w;
    logic [7:0] nxt_byte;

    // ----------------------------------------------------------------
    // Read words
    // ----------------------------------------------------------------
    always_comb
    begin
        case (s.mode)
            itrm_pkg::MODE_SM: rate_khz = itrm_pkg::RATE_SM_KHZ;
            itrm_pkg::MODE_FMP: rate_khz = itrm_pkg::RATE_FMP_KHZ;
            default: rate_khz = itrm_pkg::RATE_FM_KHZ;
        endcase
        case (s.ptr)
            itrm_pkg::REG_WIN_LEN: rd_w = {s.len_pend, 16'hffff};
            itrm_pkg::REG_LINK_STATE: rd_w = {status.busy, status.response_waiting,
                itrm_pkg::FEATURE_BITS, itrm_pkg::LAYER_BITS, status.resp_len};
            itrm_pkg::REG_TOP_RATE: rd_w = rate_khz;
            itrm_pkg::REG_GAP: rd_w = itrm_pkg::GAP_VALUE;
            itrm_pkg::REG_SPEED_MODE: rd_w = {13'h0000, s.mode, 16'hffff};
            default: rd_w = itrm_pkg::UNMAPPED_WORD;
        endcase
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        n = s;
        n.rx_valid = 1'b0;
        n.tx_taken = 1'b0;
        n.persist_wr = 1'b0;
        nxt_byte = 8'hff;
        n.scl_s = {s.scl_s[1:0], scl_i};
        n.sda_s = {s.sda_s[1:0], sda_i};
        // A pin level counts only once the last two stages agree.
        scl_new = (s.scl_s[1] == s.scl_s[2]) ? s.scl_s[2] : s.scl_f;
        sda_new = (s.sda_s[1] == s.sda_s[2]) ? s.sda_s[2] : s.sda_f;
        n.scl_f = scl_new;
        n.sda_f = sda_new;
        scl_rise = !s.scl_f && scl_new;
        scl_fall = s.scl_f && !scl_new;
        start_ev = s.scl_f && scl_new && s.sda_f && !sda_new;
        stop_ev = s.scl_f && scl_new && !s.sda_f && sda_new;
        n.payload = s.len_act - itrm_pkg::FRAME_OVERHEAD;

        if (!s.loaded)
        begin
            n.loaded = 1'b1;
            if (stored_valid)
            begin
                n.addr_act = stored_addr;
                n.addr_pend = stored_addr;
            end
        end

        if (start_ev || stop_ev)
        begin
            // Register writes commit only at the frame boundary.
            if (s.ptr_ok && s.wcnt == itrm_pkg::REG16_BYTES)
            begin
                case (s.ptr)
                    itrm_pkg::REG_WIN_LEN:
                    begin
                        if (s.wsh[15:0] > itrm_pkg::MAX_WIN_LEN)
                            n.len_pend = itrm_pkg::MAX_WIN_LEN;
                        else if (s.wsh[15:0] >= itrm_pkg::MIN_WIN_LEN)
                            n.len_pend = s.wsh[15:0];
                    end
                    itrm_pkg::REG_TARGET_ADDR:
                    begin
                        n.addr_pend = s.wsh[6:0];
                        if (s.wsh[itrm_pkg::ADDR_PERSIST_BIT])
                        begin
                            n.persist_wr = 1'b1;
                            n.persist_addr = s.wsh[6:0];
                        end
                    end
                    itrm_pkg::REG_SPEED_MODE:
                    begin
                        if (s.wsh[2:0] >= itrm_pkg::MODE_SM && s.wsh[2:0] <= itrm_pkg::MODE_FMP)
                            n.mode = s.wsh[2:0];
                    end
                    default:
                    begin
                    end
                endcase
            end
            n.ptr_ok = 1'b0;
            n.wcnt = 3'h0;
            n.sda_oe = 1'b0;
            n.bcnt = 4'h0;
            n.fsm = itrm_pkg::ST_IDLE;
        end
        if (start_ev)
        begin
            // Pending values from earlier accesses become live here.
            n.len_act = s.len_pend;
            n.addr_act = s.addr_pend;
            n.fsm = itrm_pkg::ST_ADDR;
        end
        else if (!stop_ev)
        begin
            if (scl_rise && (s.fsm == itrm_pkg::ST_ADDR || s.fsm == itrm_pkg::ST_RX_BYTE))
            begin
                n.sh = {s.sh[6:0], sda_new};
                n.bcnt = s.bcnt + 4'h1;
            end
            case (s.fsm)
                itrm_pkg::ST_ADDR:
                begin
                    if (scl_fall && s.bcnt == itrm_pkg::BITS_PER_BYTE)
                    begin
                        n.bcnt = 4'h0;
                        if (s.sh[7:1] == s.addr_act)
                        begin
                            n.fsm = itrm_pkg::ST_ADDR_ACK;
                            n.sda_oe = 1'b1;
                            n.rw = s.sh[0];
                        end
                        else
                            n.fsm = itrm_pkg::ST_IDLE;
                    end
                end
                itrm_pkg::ST_ADDR_ACK:
                begin
                    if (scl_fall)
                    begin
                        if (s.rw)
                        begin
                            // A read always uses the pointer of the last selection.
                            if (s.ptr == itrm_pkg::REG_PAYLOAD)
                            begin
                                nxt_byte = tx_data;
                                n.tx_taken = 1'b1;
                            end
                            else
                            begin
                                nxt_byte = rd_w[31:24];
                                n.rdsh = {rd_w[23:0], 8'hff};
                            end
                            n.sh = nxt_byte;
                            n.sda_oe = !nxt_byte[7];
                            n.fsm = itrm_pkg::ST_TX_BYTE;
                        end
                        else
                        begin
                            n.sda_oe = 1'b0;
                            n.fsm = itrm_pkg::ST_RX_BYTE;
                        end
                    end
                end
                itrm_pkg::ST_RX_BYTE:
                begin
                    if (scl_fall && s.bcnt == itrm_pkg::BITS_PER_BYTE)
                    begin
                        n.bcnt = 4'h0;
                        n.sda_oe = 1'b1;
                        n.fsm = itrm_pkg::ST_RX_ACK;
                        if (!s.ptr_ok)
                        begin
                            n.ptr = s.sh;
                            n.ptr_ok = 1'b1;
                            n.wsh = 32'h0000_0000;
                        end
                        else if (s.ptr == itrm_pkg::REG_PAYLOAD)
                        begin
                            n.rx_byte = s.sh;
                            n.rx_valid = 1'b1;
                        end
                        else if (s.wcnt != 3'h7)
                        begin
                            n.wsh = {s.wsh[23:0], s.sh};
                            n.wcnt = s.wcnt + 3'h1;
                        end
                    end
                end
                itrm_pkg::ST_RX_ACK:
                begin
                    if (scl_fall)
                    begin
                        n.sda_oe = 1'b0;
                        n.fsm = itrm_pkg::ST_RX_BYTE;
                    end
                end
                itrm_pkg::ST_TX_BYTE:
                begin
                    if (scl_fall)
                    begin
                        if (s.bcnt == 4'h7)
                        begin
                            n.bcnt = 4'h0;
                            n.sda_oe = 1'b0;
                            n.fsm = itrm_pkg::ST_TX_ACK;
                        end
                        else
                        begin
                            n.bcnt = s.bcnt + 4'h1;
                            n.sh = {s.sh[6:0], 1'b1};
                            n.sda_oe = !s.sh[6];
                        end
                    end
                end
                itrm_pkg::ST_TX_ACK:
                begin
                    if (scl_rise)
                        n.nack = sda_new;
                    if (scl_fall)
                    begin
                        if (s.nack)
                            n.fsm = itrm_pkg::ST_IDLE;
                        else
                        begin
                            if (s.ptr == itrm_pkg::REG_PAYLOAD)
                            begin
                                nxt_byte = tx_data;
                                n.tx_taken = 1'b1;
                            end
                            else
                            begin
                                nxt_byte = s.rdsh[31:24];
                                n.rdsh = {s.rdsh[23:0], 8'hff};
                            end
                            n.sh = nxt_byte;
                            n.sda_oe = !nxt_byte[7];
                            n.fsm = itrm_pkg::ST_TX_BYTE;
                        end
                    end
                end
                default:
                begin
                end
            endcase
        end

        if (!rst_b)
        begin
            n = '0;
            n.scl_s = 3'h7;
            n.sda_s = 3'h7;
            n.scl_f = 1'b1;
            n.sda_f = 1'b1;
            n.fsm = itrm_pkg::ST_IDLE;
            n.len_act = itrm_pkg::MAX_WIN_LEN;
            n.len_pend = itrm_pkg::MAX_WIN_LEN;
            n.addr_act = itrm_pkg::DEF_TARGET_ADDR;
            n.addr_pend = itrm_pkg::DEF_TARGET_ADDR;
            n.mode = itrm_pkg::MODE_SM_FM;
            n.payload = itrm_pkg::MAX_WIN_LEN - itrm_pkg::FRAME_OVERHEAD;
        end
    end

    always_ff @(posedge clk)
    begin
        s <= n;
    end

    assign sda_o = 1'b0;
    assign sda_oe = s.sda_oe;
    assign tx_taken = s.tx_taken;
    assign rx_byte = s.rx_byte;
    assign rx_valid = s.rx_valid;
    assign persist_wr = s.persist_wr;
    assign persist_addr = s.persist_addr;
    assign max_frame_payload = s.payload;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_frame_edge;
        start_ev;
    endsequence

    a_len_floor: assert property (s.len_pend >= itrm_pkg::MIN_WIN_LEN)
        else $error("window length below minimum");
    a_len_clamp: assert property (s.len_pend <= itrm_pkg::MAX_WIN_LEN)
        else $error("window length above capacity");
    a_payload_calc: assert property (##1 max_frame_payload == $past(s.len_act) - 16'h0005)
        else $error("frame payload not length minus five");
    a_len_defer: assert property (!start_ev |=> $stable(s.len_act))
        else $error("window length changed mid access");
    a_len_live: assert property (s_frame_edge |=> s.len_act == $past(s.len_pend))
        else $error("pending window length not made live at start");
    a_addr_defer: assert property (s.loaded && !start_ev |=> $stable(s.addr_act))
        else $error("target address changed mid access");
    a_mode_legal: assert property (s.mode >= 3'h1 && s.mode <= 3'h4)
        else $error("illegal speed code stored");
    a_persist_pulse: assert property (persist_wr |=> !persist_wr && persist_addr == $past(persist_addr))
        else $error("persist strobe not a single pulse");
    a_rx_payload: assert property (rx_valid |-> s.ptr == itrm_pkg::REG_PAYLOAD && s.fsm == itrm_pkg::ST_RX_ACK)
        else $error("payload byte outside payload register");
    a_rate_track: assert property (s.mode == 3'h4 |-> rate_khz == 32'd1000)
        else $error("fast plus rate wrong");
    a_state_word: assert property (s.ptr == itrm_pkg::REG_LINK_STATE |-> rd_w[31] == status.busy && rd_w[30] == status.response_waiting)
        else $error("link state flags wrong");

endmodule : itrm_target

`default_nettype wire

// ===== test/itrm_host.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// Two-wire host that drives the target's link pins
// ----------------------------------------------------------------
module itrm_host (
    input wire logic clk,
    input wire logic sda_oe,
    output logic scl,
    output var logic sda
);
    localparam int HALF = 7;
    logic scl_r = 1'b1;
    logic pull_r = 1'b0;

    // The data line has a pull-up, so whatever nobody pulls reads high.
    assign sda = !(pull_r || sda_oe);
    assign scl = scl_r;

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wt

    // Data moves only well after the clock has fallen, so the target never sees a false edge.
    task automatic bit_io(input logic b, output logic r);
        pull_r = !b;
        wt(HALF);
        scl_r = 1'b1;
        wt(HALF);
        r = sda;
        scl_r = 1'b0;
        wt(3);
    endtask : bit_io

    task automatic start();
        pull_r = 1'b0;
        wt(HALF);
        scl_r = 1'b1;
        wt(HALF);
        pull_r = 1'b1;
        wt(HALF);
        scl_r = 1'b0;
        wt(HALF);
    endtask : start

    task automatic stop();
        pull_r = 1'b1;
        wt(HALF);
        scl_r = 1'b1;
        wt(HALF);
        pull_r = 1'b0;
        wt(HALF);
    endtask : stop

    task automatic byte_io(input logic [7:0] d, input logic ak, output logic [7:0] q,
                           output logic got);
        logic a;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(ak, a);
        got = !a;
    endtask : byte_io

    task automatic access(input logic [6:0] dev, input logic [7:0] rg, input logic rdn,
                          input int n, input logic [31:0] wd, output logic [31:0] rdat,
                          output logic ok);
        logic [7:0] q;
        logic a;
        ok = 1'b1;
        rdat = '0;
        start();
        byte_io({dev, 1'b0}, 1'b1, q, a);
        ok &= a;
        byte_io(rg, 1'b1, q, a);
        ok &= a;
        if (rdn)
        begin
            start();
            byte_io({dev, 1'b1}, 1'b1, q, a);
            ok &= a;
            for (int i = 0; i < n; i++)
            begin
                byte_io(8'hff, (i == n - 1), q, a);
                rdat = {rdat[23:0], q};
            end
        end
        else
        begin
            for (int i = 0; i < n; i++)
            begin
                byte_io(wd[8 * (n - 1 - i) +: 8], 1'b1, q, a);
                ok &= a;
            end
        end
        stop();
    endtask : access
endmodule : itrm_host

`default_nettype wire

// ===== test/tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    wire logic scl;
    wire logic sda;
    logic sda_o, sda_oe, tx_taken, rx_valid, persist_wr;
    itrm_pkg::itrm_status_t status;
    wire logic [7:0] tx_data;
    logic [7:0] rx_byte;
    logic stored_valid = 1'b0;
    logic wipe = 1'b0;
    logic [6:0] stored_addr = 7'h00;
    logic [6:0] persist_addr;
    logic [15:0] max_frame_payload, cur, v;
    logic [31:0] rd, w;
    logic ok;
    logic [2:0] md;
    logic [7:0] rxq[$];
    logic [7:0] txv[4];
    int txi = 0;
    int pw_cnt = 0;
    int t0;
    int err_count = 0;
    int samples_checked = 0;

    initial forever #4 clk = ~clk;

    itrm_target u_dut (.clk(clk), .rst_b(rst_b), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .status(status), .tx_data(tx_data), .tx_taken(tx_taken),
        .rx_byte(rx_byte), .rx_valid(rx_valid), .stored_valid(stored_valid),
        .stored_addr(stored_addr), .persist_wr(persist_wr), .persist_addr(persist_addr),
        .max_frame_payload(max_frame_payload));
    itrm_host u_host (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));

    // ----------------------------------------------------------------
    // Far-side stand-ins: payload source and sink, persistent store
    // ----------------------------------------------------------------
    assign tx_data = txv[txi[1:0]];
    always @(posedge clk)
    begin
        if (tx_taken === 1'b1)
            txi <= txi + 1;
        if (rx_valid === 1'b1)
            rxq.push_back(rx_byte);
        if (persist_wr === 1'b1)
        begin
            pw_cnt <= pw_cnt + 1;
            stored_valid <= 1'b1;
            stored_addr <= persist_addr;
        end
        else if (wipe)
            stored_valid <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize

    task automatic do_reset();
        rst_b = 1'b0;
        repeat (10) @(posedge clk);
        #1;
        rst_b = 1'b1;
        repeat (8) @(posedge clk);
        #1;
    endtask : do_reset

    task automatic acc(input logic [6:0] dev, input logic [7:0] rg, input logic rdn,
                       input int n, input logic [31:0] wd);
        u_host.access(dev, rg, rdn, n, wd, rd, ok);
    endtask : acc

    function automatic logic [15:0] exp_len(input logic [15:0] x, input logic [15:0] old);
        if (x < itrm_pkg::MIN_WIN_LEN)
            return old;
        if (x > itrm_pkg::MAX_WIN_LEN)
            return itrm_pkg::MAX_WIN_LEN;
        return x;
    endfunction : exp_len

    function automatic logic [31:0] exp_rate(input logic [2:0] m);
        case (m)
            itrm_pkg::MODE_SM: return itrm_pkg::RATE_SM_KHZ;
            itrm_pkg::MODE_FMP: return itrm_pkg::RATE_FMP_KHZ;
            default: return itrm_pkg::RATE_FM_KHZ;
        endcase
    endfunction : exp_rate

    // The host tasks never wait on an acknowledge, so a missing one only clears ok; cap the whole run anyway.
    initial
    begin
        repeat (95000) @(posedge clk);
        err_count++;
        summarize();
    end

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial
    begin
        status = '0;
        txv = '{8'h00, 8'h00, 8'h00, 8'h00};
        t0 = $urandom(32'ha22e);
        do_reset();
        cur = itrm_pkg::MAX_WIN_LEN;
        chk(32'(max_frame_payload), 32'(cur - itrm_pkg::FRAME_OVERHEAD));
        acc(itrm_pkg::DEF_TARGET_ADDR, itrm_pkg::REG_WIN_LEN, 1'b1, 2, 0);
        chk(32'(ok), 32'h1);
        chk(rd, 32'(cur));
        acc(7'h31, itrm_pkg::REG_WIN_LEN, 1'b1, 2, 0);
        chk(32'(ok), 32'h0);
        $display("test reset done");

        for (int i = 0; i < 8; i++)
        begin
            case (i)
                0: v = 16'h0010;
                1: v = 16'h000f;
                2: v = 16'h0201;
                3: v = 16'hffff;
                default: v = 16'h0010 + 16'($urandom_range(0, 32'hffef));
            endcase
            acc(itrm_pkg::DEF_TARGET_ADDR, itrm_pkg::REG_WIN_LEN, 1'b0, 2, 32'(v));
            chk(32'(max_frame_payload), 32'(cur - itrm_pkg::FRAME_OVERHEAD));
            cur = exp_len(v, cur);
            acc(itrm_pkg::DEF_TARGET_ADDR, itrm_pkg::REG_WIN_LEN, 1'b1, 2, 0);
            chk(rd, 32'(cur));
            chk(32'(max_frame_payload), 32'(cur - itrm_pkg::FRAME_OVERHEAD));
        end
        $display("test window done");

        for (int i = 0; i < 6; i++)
        begin
            w = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : $urandom;
            status = w[17:0];
            acc(itrm_pkg::DEF_TARGET_ADDR, itrm_pkg::REG_LINK_STATE, 1'b1, 4, 0);
            chk(rd, {w[17:16], itrm_pkg::FEATURE_BITS, itrm_pkg::LAYER_BITS, w[15:0]});
        end
        $display("test state done");

        md = itrm_pkg::MODE_SM_FM;
        for (int c = 0; c < 8; c++)
        begin
            acc(itrm_pkg::DEF_TARGET_ADDR, itrm_pkg::REG_SPEED_MODE, 1'b0, 2, 32'(c));
            if (c >= 1 && c <= 4)
                md = 3'(c);
            acc(itrm_pkg::DEF_TARGET_ADDR, itrm_pkg::REG_TOP_RATE, 1'b1, 4, 0);
            chk(rd, exp_rate(md));
            acc(itrm_pkg::DEF_TARGET_ADDR, itrm_pkg::REG_SPEED_MODE, 1'b1, 2, 0);
            chk(rd, 32'(md));
        end
        $display("test speed done");

        foreach (txv[i])
            txv[i] = 8'($urandom);
        w = 32'($urandom_range(0, 32'h00ff_ffff));
        t0 = rxq.size();
        acc(itrm_pkg::DEF_TARGET_ADDR, itrm_pkg::REG_PAYLOAD, 1'b0, 3, w);
        chk(32'(rxq.size() - t0), 32'h3);
        for (int i = 0; i < 3; i++)
            chk(32'(rxq[t0 + i]), 32'(w[8 * (2 - i) +: 8]));
        t0 = txi;
        acc(itrm_pkg::DEF_TARGET_ADDR, itrm_pkg::REG_PAYLOAD, 1'b1, 2, 0);
        chk(rd, {16'h0000, txv[t0 % 4], txv[(t0 + 1) % 4]});
        chk(32'(txi - t0), 32'h2);
        $display("test payload done");

        acc(itrm_pkg::DEF_TARGET_ADDR, itrm_pkg::REG_TARGET_ADDR, 1'b0, 2, 32'h0042);
        chk(32'(ok), 32'h1);
        acc(itrm_pkg::DEF_TARGET_ADDR, itrm_pkg::REG_WIN_LEN, 1'b1, 2, 0);
        chk(32'(ok), 32'h0);
        acc(7'h42, itrm_pkg::REG_TARGET_ADDR, 1'b0, 2, 32'h8055);
        chk(32'(ok), 32'h1);
        chk(32'(pw_cnt), 32'h1);
        chk(32'(stored_addr), 32'h55);
        do_reset();
        acc(7'h55, itrm_pkg::REG_WIN_LEN, 1'b1, 2, 0);
        chk(32'(ok), 32'h1);
        wipe = 1'b1;
        @(posedge clk);
        #1;
        wipe = 1'b0;
        do_reset();
        acc(itrm_pkg::DEF_TARGET_ADDR, itrm_pkg::REG_WIN_LEN, 1'b1, 2, 0);
        chk(32'(ok), 32'h1);
        $display("test address done");
        summarize();
    end
endmodule : tb

`default_nettype wire
